// *** verilog/analog_position_ramp_scaler.v ***
// position to analogue output ramp scaler: travel definition, teach capture, scaling
// assumes position, commands and configuration are synchronous to i_clk
`include "analog_position_ramp_scaler_map.vh"

module analog_position_ramp_scaler #(
  parameter POS_W = 26,
  parameter CODE_W = 16
) (
  // clock and reset
  input wire i_clk,
  input wire i_reset,
  // position sensing
  input wire [POS_W-1:0] i_raw_position,
  input wire i_complement,
  // configuration, taken on i_cfg_load
  input wire i_cfg_load,
  input wire i_cfg_current,
  input wire [1:0] i_cfg_range,
  input wire [1:0] i_cfg_mode,
  input wire i_cfg_out_enable,
  input wire i_cfg_dir_inverted,
  input wire [POS_W:0] i_travel_length_counts,
  // teach commands
  input wire i_start_teach,
  input wire i_stop_teach,
  // converter side
  output reg [CODE_W-1:0] o_dac_code,
  output wire o_vout_enable,
  output wire o_iout_enable,
  output wire o_kind_current,
  output wire [1:0] o_range,
  // status
  output wire [1:0] o_mode,
  output wire [POS_W-1:0] o_position,
  output wire o_teach_armed,
  output wire [1:0] o_error_code,
  output wire o_travel_done
);

  // ****************************************************************
  // configuration
  // ****************************************************************
  reg kind_q;
  reg [1:0] range_q;
  reg [1:0] mode_q;
  reg out_enable_q;
  reg dir_inverted_q;
  reg [POS_W:0] count_len_q;
  reg [1:0] range_d;
  reg [POS_W:0] count_len_d;

  always @* begin
    range_d = i_cfg_range;
    // the fourth code is no current scale; keep a valid one instead
    if (i_cfg_current && i_cfg_range == 2'h3) begin
      range_d = (range_q == 2'h3) ? `RANGE_I_4_20 : range_q;
    end
    count_len_d = i_travel_length_counts;
    if (i_travel_length_counts == {(POS_W+1){1'b0}}) begin
      count_len_d = count_len_q;
    end else if (i_travel_length_counts > `FULL_RESOLUTION) begin
      count_len_d = `FULL_RESOLUTION;
    end
  end

  always @(posedge i_clk) begin
    if (i_reset) begin
      kind_q <= `RST_KIND;
      range_q <= `RST_RANGE;
      mode_q <= `RST_MODE;
      out_enable_q <= `RST_OUT_ENABLE;
      dir_inverted_q <= `RST_DIR_INVERTED;
      count_len_q <= `RST_LENGTH;
    end else if (i_cfg_load) begin
      kind_q <= i_cfg_current;
      range_q <= range_d;
      mode_q <= i_cfg_mode;
      out_enable_q <= i_cfg_out_enable;
      dir_inverted_q <= i_cfg_dir_inverted;
      count_len_q <= count_len_d;
    end
  end

  wire mode_cyclic = mode_q[`MODE_CYCLIC_BIT];
  wire mode_counted = mode_q[`MODE_COUNTED_BIT];

  // ****************************************************************
  // position
  // ****************************************************************
  // preset is not applied here; the operator re-applies it upstream
  wire [POS_W-1:0] pos;

  position_direction #(
    .POS_W(POS_W)
  ) u_direction (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_dir_inverted(dir_inverted_q),
    .i_complement(i_complement),
    .i_raw_position(i_raw_position),
    .o_position(pos)
  );

  // ****************************************************************
  // capture by motion
  // ****************************************************************
  reg [POS_W-1:0] origin_q;
  reg [POS_W:0] taught_len_q;
  reg travel_neg_q;
  reg [POS_W-1:0] cand_origin_q;
  reg [POS_W-1:0] prev_pos_q;
  reg signed [POS_W+1:0] disp_q;
  reg armed_q;
  reg moved_pos_q;
  reg moved_neg_q;
  reg reversed_q;
  reg too_far_q;
  reg [1:0] error_q;
  reg done_q;

  // wrap-aware step between successive positions
  wire [POS_W-1:0] step = pos - prev_pos_q;
  wire signed [POS_W+1:0] disp_next = disp_q + {{2{step[POS_W-1]}}, step};
  wire [POS_W+1:0] disp_abs = disp_next[POS_W+1] ? (~disp_next + 1'b1) : disp_next;
  wire teach_ok = ~mode_counted;
  wire start_cmd = i_start_teach & teach_ok;
  wire stop_cmd = i_stop_teach & teach_ok & armed_q;

  always @(posedge i_clk) begin
    if (i_reset) begin
      origin_q <= `RST_ORIGIN;
      taught_len_q <= `RST_LENGTH;
      travel_neg_q <= 1'b0;
      cand_origin_q <= {POS_W{1'b0}};
      prev_pos_q <= {POS_W{1'b0}};
      disp_q <= {(POS_W+2){1'b0}};
      armed_q <= 1'b0;
      moved_pos_q <= 1'b0;
      moved_neg_q <= 1'b0;
      reversed_q <= 1'b0;
      too_far_q <= 1'b0;
      error_q <= `ERR_NONE;
      done_q <= 1'b0;
    end else begin
      prev_pos_q <= pos;
      done_q <= 1'b0;
      if (stop_cmd) begin
        armed_q <= 1'b0;
        done_q <= 1'b1;
        // failing checks leave origin and length untouched
        if (disp_next == {(POS_W+2){1'b0}}) begin
          error_q <= `ERR_MIN_STROKE;
        end else if (too_far_q || disp_abs >= {1'b0, `FULL_RESOLUTION}) begin
          error_q <= `ERR_RESOLUTION;
        end else if (reversed_q ||
                     (moved_pos_q && disp_next < 0) ||
                     (moved_neg_q && disp_next > 0)) begin
          error_q <= `ERR_REVERSAL;
        end else begin
          error_q <= `ERR_NONE;
          origin_q <= cand_origin_q;
          taught_len_q <= disp_abs[POS_W:0] + 1'b1;
          travel_neg_q <= disp_next[POS_W+1];
        end
      end else if (start_cmd) begin
        // the axis is expected at the origin now and moved afterwards
        cand_origin_q <= pos;
        disp_q <= {(POS_W+2){1'b0}};
        armed_q <= 1'b1;
        moved_pos_q <= 1'b0;
        moved_neg_q <= 1'b0;
        reversed_q <= 1'b0;
        too_far_q <= 1'b0;
        error_q <= `ERR_NONE;
      end else if (armed_q) begin
        disp_q <= disp_next;
        if (disp_next > 0) begin
          moved_pos_q <= 1'b1;
        end
        if (disp_next < 0) begin
          moved_neg_q <= 1'b1;
        end
        if ((moved_pos_q && disp_next < 0) || (moved_neg_q && disp_next > 0)) begin
          reversed_q <= 1'b1;
        end
        // sticky so that a later wrap of the accumulator cannot hide it
        if (disp_abs >= {1'b0, `FULL_RESOLUTION}) begin
          too_far_q <= 1'b1;
        end
      end
      if (mode_counted) begin
        armed_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // effective travel
  // ****************************************************************
  wire [POS_W-1:0] eff_origin = mode_counted ? {POS_W{1'b0}} : origin_q;
  wire [POS_W:0] eff_len = mode_counted ? count_len_q : taught_len_q;
  wire eff_neg = ~mode_counted & travel_neg_q;
  wire [POS_W:0] len_m1 = eff_len - 1'b1;
  wire signed [POS_W:0] ofs = eff_neg ? ({1'b0, eff_origin} - {1'b0, pos}) :
                                        ({1'b0, pos} - {1'b0, eff_origin});

  // ****************************************************************
  // scaling sequence
  // ****************************************************************
  localparam ST_IDLE = 2'd0;
  localparam ST_MOD = 2'd1;
  localparam ST_SCALE = 2'd2;
  localparam NUM_W = POS_W + CODE_W;

  reg [1:0] state_q;
  reg div_start_q;
  reg [NUM_W-1:0] div_num_q;
  reg [POS_W:0] div_den_q;
  reg [CODE_W-1:0] code_q;
  wire div_done;
  wire [NUM_W-1:0] div_quot;
  wire [POS_W:0] div_rem;
  wire [NUM_W:0] ofs_prod = {1'b0, ofs[POS_W-1:0], {CODE_W{1'b0}}} -
                            {{(CODE_W+1){1'b0}}, ofs[POS_W-1:0]};
  wire [NUM_W:0] rem_prod = {1'b0, div_rem[POS_W-1:0], {CODE_W{1'b0}}} -
                            {{(CODE_W+1){1'b0}}, div_rem[POS_W-1:0]};

  ramp_divider #(
    .NUM_W(NUM_W),
    .DEN_W(POS_W + 1),
    .CNT_W(6)
  ) u_divider (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_start(div_start_q),
    .i_num(div_num_q),
    .i_den(div_den_q),
    .o_done(div_done),
    .o_quot(div_quot),
    .o_rem(div_rem)
  );

  // the long division trades latency for area; the code lags motion by ~90 cycles in cyclic modes, ~45 in single ones
  always @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      div_start_q <= 1'b0;
      div_num_q <= {NUM_W{1'b0}};
      div_den_q <= {(POS_W+1){1'b0}};
      code_q <= `RAMP_CODE_MIN;
    end else begin
      div_start_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (mode_cyclic) begin
            div_num_q <= {{CODE_W{1'b0}}, ofs[POS_W-1:0]};
            div_den_q <= eff_len;
            div_start_q <= 1'b1;
            state_q <= ST_MOD;
          end else if (ofs < 0) begin
            code_q <= `RAMP_CODE_MIN;
          end else if (ofs >= $signed(len_m1)) begin
            code_q <= `RAMP_CODE_MAX;
          end else begin
            div_num_q <= ofs_prod[NUM_W-1:0];
            div_den_q <= len_m1;
            div_start_q <= 1'b1;
            state_q <= ST_SCALE;
          end
        end
        ST_MOD: begin
          if (div_done) begin
            if (len_m1 == {(POS_W+1){1'b0}}) begin
              code_q <= `RAMP_CODE_MIN;
              state_q <= ST_IDLE;
            end else begin
              div_num_q <= rem_prod[NUM_W-1:0];
              div_den_q <= len_m1;
              div_start_q <= 1'b1;
              state_q <= ST_SCALE;
            end
          end
        end
        ST_SCALE: begin
          if (div_done) begin
            code_q <= `RAMP_CODE_MIN + div_quot[CODE_W-1:0];
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // converter outputs
  // ****************************************************************
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_dac_code <= `RAMP_CODE_MIN;
    end else if (out_enable_q) begin
      o_dac_code <= code_q;
    end else begin
      o_dac_code <= `RAMP_CODE_MIN;
    end
  end

  assign o_vout_enable = out_enable_q & (kind_q == `KIND_VOLTAGE);
  assign o_iout_enable = out_enable_q & (kind_q == `KIND_CURRENT);
  assign o_kind_current = kind_q;
  assign o_range = range_q;
  assign o_mode = mode_q;
  assign o_position = pos;
  assign o_teach_armed = armed_q;
  assign o_error_code = error_q;
  assign o_travel_done = done_q;

endmodule

// *** verilog/analog_position_ramp_scaler_map.vh ***
// constants for the position to analogue ramp scaler
// assumes inclusion by bare name from the scaler and direction stage design files of the block
`ifndef ANALOG_POSITION_RAMP_SCALER_MAP_VH
`define ANALOG_POSITION_RAMP_SCALER_MAP_VH

// ****************************************************************
// output kind and range codes
// ****************************************************************
`define KIND_VOLTAGE 1'b0
`define KIND_CURRENT 1'b1
`define RANGE_I_4_20 2'h0
`define RANGE_I_0_20 2'h1
`define RANGE_I_0_24 2'h2
`define RANGE_V_0_5 2'h0
`define RANGE_V_0_10 2'h1
`define RANGE_V_PM5 2'h2
`define RANGE_V_PM10 2'h3

// ****************************************************************
// programming modes
// ****************************************************************
`define MODE_TAUGHT_SINGLE 2'h0
`define MODE_TAUGHT_CYCLIC 2'h1
`define MODE_COUNT_SINGLE 2'h2
`define MODE_COUNT_CYCLIC 2'h3
`define MODE_CYCLIC_BIT 0
`define MODE_COUNTED_BIT 1

// ****************************************************************
// error codes
// ****************************************************************
`define ERR_NONE 2'h0
`define ERR_MIN_STROKE 2'h1
`define ERR_RESOLUTION 2'h2
`define ERR_REVERSAL 2'h3

// ****************************************************************
// converter codes and reset values
// ****************************************************************
`define RAMP_CODE_MIN 16'h0000
`define RAMP_CODE_MAX 16'hFFFF
`define RAMP_CODE_SPAN 16'hFFFF
`define RST_KIND `KIND_VOLTAGE
`define RST_RANGE `RANGE_V_0_5
`define RST_MODE `MODE_TAUGHT_SINGLE
`define RST_OUT_ENABLE 1'b1
`define RST_DIR_INVERTED 1'b0
`define RST_LENGTH 27'h4000000
`define RST_ORIGIN 26'h0000000
`define FULL_RESOLUTION 27'h4000000

`endif

// *** verilog/position_direction.v ***
// position direction stage: applies the counting direction to the sensor position
// assumes a 26-bit absolute position synchronous to i_clk
`include "analog_position_ramp_scaler_map.vh"

module position_direction #(
  parameter POS_W = 26
) (
  // clock and reset
  input wire i_clk,
  input wire i_reset,
  // controls
  input wire i_dir_inverted,
  input wire i_complement,
  // positions
  input wire [POS_W-1:0] i_raw_position,
  output reg [POS_W-1:0] o_position
);

  // ****************************************************************
  // direction
  // ****************************************************************
  // either inversion alone reverses the count, both cancel out
  wire invert = i_dir_inverted ^ i_complement;

  always @(posedge i_clk) begin
    if (i_reset) begin
      o_position <= {POS_W{1'b0}};
    end else if (invert) begin
      o_position <= ~i_raw_position;
    end else begin
      o_position <= i_raw_position;
    end
  end

endmodule

// *** verilog/ramp_divider.v ***
// sequential restoring divider, one quotient bit per clock
// assumes the caller never starts with a zero divisor and waits for done
module ramp_divider #(
  parameter NUM_W = 42,
  parameter DEN_W = 27,
  parameter CNT_W = 6
) (
  // clock and reset
  input wire i_clk,
  input wire i_reset,
  // request
  input wire i_start,
  input wire [NUM_W-1:0] i_num,
  input wire [DEN_W-1:0] i_den,
  // answer
  output wire o_done,
  output wire [NUM_W-1:0] o_quot,
  output wire [DEN_W-1:0] o_rem
);

  // ****************************************************************
  // iteration
  // ****************************************************************
  reg [NUM_W-1:0] quot_q;
  reg [DEN_W:0] rem_q;
  reg [DEN_W-1:0] den_q;
  reg [CNT_W-1:0] cnt_q;
  reg busy_q;
  reg done_q;
  wire [DEN_W:0] trial = {rem_q[DEN_W-1:0], quot_q[NUM_W-1]};
  wire [DEN_W:0] diff = trial - {1'b0, den_q};
  wire fits = (trial >= {1'b0, den_q});

  always @(posedge i_clk) begin
    if (i_reset) begin
      quot_q <= {NUM_W{1'b0}};
      rem_q <= {(DEN_W+1){1'b0}};
      den_q <= {DEN_W{1'b0}};
      cnt_q <= {CNT_W{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (i_start) begin
        quot_q <= i_num;
        rem_q <= {(DEN_W+1){1'b0}};
        den_q <= i_den;
        cnt_q <= NUM_W[CNT_W-1:0];
        busy_q <= 1'b1;
      end else if (busy_q) begin
        quot_q <= {quot_q[NUM_W-2:0], fits};
        rem_q <= fits ? diff : trial;
        cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
        if (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign o_done = done_q;
  assign o_quot = quot_q;
  assign o_rem = rem_q[DEN_W-1:0];

endmodule

// *** sim/analog_position_ramp_scaler_chk.sv ***
// concurrent checks on the position ramp scaler ports
// assumes binding to the top module, single clock, synchronous reset
module analog_position_ramp_scaler_chk #(
  parameter POS_W = 26,
  parameter CODE_W = 16
) (
  input wire i_clk,
  input wire i_reset,
  input wire [POS_W-1:0] i_raw_position,
  input wire i_complement,
  input wire i_cfg_load,
  input wire i_cfg_current,
  input wire [1:0] i_cfg_range,
  input wire [1:0] i_cfg_mode,
  input wire i_cfg_dir_inverted,
  input wire i_start_teach,
  input wire i_stop_teach,
  input wire [CODE_W-1:0] o_dac_code,
  input wire o_vout_enable,
  input wire o_iout_enable,
  input wire o_kind_current,
  input wire [1:0] o_range,
  input wire [1:0] o_mode,
  input wire [POS_W-1:0] o_position,
  input wire o_teach_armed,
  input wire [1:0] o_error_code,
  input wire o_travel_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ****************************************************************
  // helper state
  // ****************************************************************
  // direction setting is not a port, so it is tracked from the loads
  reg dir_q;
  reg off_q;
  wire fwd = ~(dir_q ^ i_complement);
  wire teach_ok = !o_mode[1] && !i_cfg_load;
  always @(posedge i_clk) begin
    if (i_reset) begin
      dir_q <= 1'b0;
      off_q <= 1'b0;
    end else begin
      if (i_cfg_load) begin
        dir_q <= i_cfg_dir_inverted;
      end
      off_q <= !o_vout_enable && !o_iout_enable;
    end
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_kind_load: assert property (i_cfg_load |=> o_kind_current == $past(i_cfg_current))
    else $error("output kind not taken from load");
  a_pin_select: assert property ((o_vout_enable |-> !o_kind_current)
    and (o_iout_enable |-> o_kind_current))
    else $error("wrong output pin enabled for kind");
  a_cur_refuse: assert property (i_cfg_load && i_cfg_current && i_cfg_range == 2'h3 |=>
    o_range == ($past(o_range) == 2'h3 ? 2'h0 : $past(o_range)))
    else $error("fourth current range accepted");
  a_range_load: assert property (i_cfg_load && !(i_cfg_current && i_cfg_range == 2'h3) |=>
    o_range == $past(i_cfg_range))
    else $error("range not taken from load");
  a_mode_load: assert property (i_cfg_load |=> o_mode == $past(i_cfg_mode))
    else $error("mode not taken from load");
  a_start_arms: assert property (i_start_teach && teach_ok
    && !(i_stop_teach && o_teach_armed) |=> o_teach_armed && o_error_code == 2'h0)
    else $error("start command did not arm");
  a_stop_done: assert property (i_stop_teach && o_teach_armed && teach_ok |=>
    o_travel_done && !o_teach_armed ##1 !o_travel_done)
    else $error("stop command did not end travel");
  a_teach_ignored: assert property ((i_start_teach || i_stop_teach) && o_mode[1]
    && !o_teach_armed && !i_cfg_load |=> !o_teach_armed && !o_travel_done)
    else $error("teach command taken in counted mode");
  a_quiet_off: assert property (off_q && !o_vout_enable && !o_iout_enable |->
    o_dac_code == 16'h0000)
    else $error("disabled output carries a code");
  a_fwd_pos: assert property (fwd && $past(fwd) && $past(fwd, 2) && !$past(i_reset) |->
    o_position == $past(i_raw_position))
    else $error("standard direction changed the position");
  c_taught: cover property (o_travel_done && o_error_code == 2'h0);
  c_stroke: cover property (o_travel_done && o_error_code == 2'h1);
  c_reverse: cover property (o_travel_done && o_error_code == 2'h3);
  c_top: cover property (o_dac_code == 16'hFFFF);
endmodule
bind analog_position_ramp_scaler analog_position_ramp_scaler_chk #(.POS_W(POS_W), .CODE_W(CODE_W))
  u_analog_position_ramp_scaler_chk (.i_clk(i_clk), .i_reset(i_reset),
  .i_raw_position(i_raw_position), .i_complement(i_complement), .i_cfg_load(i_cfg_load),
  .i_cfg_current(i_cfg_current), .i_cfg_range(i_cfg_range), .i_cfg_mode(i_cfg_mode),
  .i_cfg_dir_inverted(i_cfg_dir_inverted), .i_start_teach(i_start_teach),
  .i_stop_teach(i_stop_teach), .o_dac_code(o_dac_code), .o_vout_enable(o_vout_enable),
  .o_iout_enable(o_iout_enable), .o_kind_current(o_kind_current), .o_range(o_range),
  .o_mode(o_mode), .o_position(o_position), .o_teach_armed(o_teach_armed),
  .o_error_code(o_error_code), .o_travel_done(o_travel_done));

// *** sim/shaft_sensor_model.sv ***
// shaft position sensor model: walks the absolute position toward a target
// assumes the bench changes target, direction and step off the rising edge
module shaft_sensor_model (
  input wire i_clk,
  input wire [25:0] i_target,
  input wire i_up,
  input wire [25:0] i_step,
  output wire [25:0] o_raw_position
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [25:0] pos_q = 26'h0000000;
  wire [25:0] gap = i_up ? i_target - pos_q : pos_q - i_target;
  wire [25:0] left = (gap > i_step) ? i_step : gap;
  // large steps wrap modulo full scale, as a multi-turn counter does
  always @(posedge i_clk) begin
    pos_q <= i_up ? pos_q + left : pos_q - left;
  end
  assign o_raw_position = pos_q;
endmodule

// *** sim/analog_position_ramp_scaler_tb.sv ***
// self-checking bench for the position ramp scaler
// assumes the checker is bound in and the sensor model drives the position
module analog_position_ramp_scaler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_reset = 1'b1, i_complement = 1'b0, i_cfg_load = 1'b0;
  logic i_cfg_current = 1'b0, i_cfg_out_enable = 1'b1, i_cfg_dir_inverted = 1'b0;
  logic [1:0] i_cfg_range = 2'h0, i_cfg_mode = 2'h0;
  logic [26:0] i_travel_length_counts = 27'h0000000;
  logic i_start_teach = 1'b0, i_stop_teach = 1'b0, dir_up = 1'b1;
  logic [25:0] target = 26'h0000000, step_size = 26'h0000001, raw, pos, p0;
  logic [15:0] code;
  logic vout, iout, kind, armed, done;
  logic [1:0] range, mode, err;
  int failures = 0, n_tests = 0;
  always #2 i_clk = ~i_clk;
  shaft_sensor_model u_shaft_sensor_model (.i_clk(i_clk), .i_target(target), .i_up(dir_up),
    .i_step(step_size), .o_raw_position(raw));
  analog_position_ramp_scaler u_analog_position_ramp_scaler (.i_clk(i_clk), .i_reset(i_reset),
    .i_raw_position(raw), .i_complement(i_complement), .i_cfg_load(i_cfg_load),
    .i_cfg_current(i_cfg_current), .i_cfg_range(i_cfg_range), .i_cfg_mode(i_cfg_mode),
    .i_cfg_out_enable(i_cfg_out_enable), .i_cfg_dir_inverted(i_cfg_dir_inverted),
    .i_travel_length_counts(i_travel_length_counts), .i_start_teach(i_start_teach),
    .i_stop_teach(i_stop_teach), .o_dac_code(code), .o_vout_enable(vout), .o_iout_enable(iout),
    .o_kind_current(kind), .o_range(range), .o_mode(mode), .o_position(pos),
    .o_teach_armed(armed), .o_error_code(err), .o_travel_done(done));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic logic [15:0] scale(input longint ofs, input longint len);
    return 16'((ofs * 65535) / (len - 1));
  endfunction
  task automatic cfg(input logic cur, input logic [1:0] rng, input logic [1:0] md,
                     input logic en, input logic dir, input logic [26:0] len);
    @(negedge i_clk);
    i_cfg_current = cur;
    i_cfg_range = rng;
    i_cfg_mode = md;
    i_cfg_out_enable = en;
    i_cfg_dir_inverted = dir;
    i_travel_length_counts = len;
    i_cfg_load = 1'b1;
    @(negedge i_clk);
    i_cfg_load = 1'b0;
  endtask
  task automatic move(input logic [25:0] tgt, input logic up, input logic [25:0] step);
    @(negedge i_clk);
    target = tgt;
    dir_up = up;
    step_size = step;
    for (int k = 0; k < 6000 && raw !== tgt; k++) @(negedge i_clk);
    repeat (2) @(negedge i_clk);
    chk("reach", raw, tgt);
  endtask
  // one pulse on start or stop, returns once the answer has landed
  task automatic teach(input logic stop);
    @(negedge i_clk);
    i_start_teach = !stop;
    i_stop_teach = stop;
    @(negedge i_clk);
    i_start_teach = 1'b0;
    i_stop_teach = 1'b0;
  endtask
  // a scaling pass takes up to about 90 cycles, so allow generous slack
  task automatic wait_code(input string name, input logic [15:0] exp);
    for (int k = 0; k < 400 && code !== exp; k++) @(negedge i_clk);
    chk(name, code, exp);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    chk("kind", kind, 0);
    chk("vout", {vout, iout}, 2'h2);
    chk("range", range, 0);
    chk("mode", mode, 0);
    $display("test reset done");
  endtask
  task automatic t_ranges;
    for (int r = 0; r < 4; r++) begin
      cfg(1'b1, 2'(r), 2'h0, 1'b1, 1'b0, 27'h0);
      chk("cur range", range, (r == 3) ? 2 : r);
      chk("iout", {vout, iout}, 2'h1);
    end
    for (int r = 0; r < 4; r++) begin
      cfg(1'b0, 2'(r), 2'h0, 1'b1, 1'b0, 27'h0);
      chk("volt range", range, r);
    end
    cfg(1'b0, 2'h0, 2'h0, 1'b1, 1'b0, 27'h0);
    $display("test ranges done");
  endtask
  task automatic t_teach;
    move(26'd1000, 1'b1, 26'd1);
    teach(1'b0);
    chk("armed", armed, 1);
    move(26'd5095, 1'b1, 26'd1);
    teach(1'b1);
    chk("done", done, 1);
    chk("err ok", err, 0);
    wait_code("at end", 16'hFFFF);
    move(26'd1000, 1'b0, 26'd64);
    wait_code("at start", 16'h0000);
    move(26'd9000, 1'b1, 26'd64);
    wait_code("after end", 16'hFFFF);
    move(26'd500, 1'b0, 26'd64);
    wait_code("before start", 16'h0000);
    move(26'd3047, 1'b1, 26'd64);
    wait_code("mid", scale(2047, 4096));
    $display("test teach done");
  endtask
  task automatic t_errors;
    teach(1'b0);
    teach(1'b1);
    chk("stroke", err, 1);
    teach(1'b0);
    move(26'd3147, 1'b1, 26'd1);
    move(26'd2947, 1'b0, 26'd1);
    teach(1'b1);
    chk("reverse", err, 3);
    wait_code("kept", scale(1947, 4096));
    teach(1'b0);
    repeat (3) move(raw + 26'h1FFFFFF, 1'b1, 26'h1FFFFFF);
    teach(1'b1);
    chk("resolution", err, 2);
    wait_code("kept end", 16'hFFFF);
    $display("test errors done");
  endtask
  task automatic t_counted;
    cfg(1'b0, 2'h1, 2'h2, 1'b1, 1'b0, 27'd4096);
    teach(1'b0);
    chk("no arm", armed, 0);
    move(26'd2047, 1'b0, 26'h0100000);
    wait_code("count mid", scale(2047, 4096));
    cfg(1'b0, 2'h1, 2'h3, 1'b1, 1'b0, 27'd4096);
    move(26'd5096, 1'b1, 26'd64);
    wait_code("cyc mid", scale(1000, 4096));
    move(26'd4096, 1'b0, 26'd64);
    wait_code("cyc wrap", 16'h0000);
    move(26'd5096, 1'b1, 26'd64);
    cfg(1'b0, 2'h1, 2'h3, 1'b0, 1'b0, 27'h0);
    chk("off pins", {vout, iout}, 2'h0);
    wait_code("off", 16'h0000);
    cfg(1'b0, 2'h1, 2'h3, 1'b1, 1'b0, 27'h0);
    wait_code("on", scale(1000, 4096));
    $display("test counted done");
  endtask
  task automatic t_dir;
    // preset is not modelled, so nothing is re-applied after the change
    cfg(1'b0, 2'h1, 2'h3, 1'b1, 1'b1, 27'h0);
    // the new direction reaches the position one edge after the load
    repeat (2) @(negedge i_clk);
    p0 = pos;
    move(raw + 26'd1, 1'b1, 26'd1);
    chk("inverted", pos, p0 - 26'd1);
    @(negedge i_clk);
    i_complement = 1'b1;
    repeat (3) @(negedge i_clk);
    p0 = pos;
    move(raw + 26'd1, 1'b1, 26'd1);
    chk("complemented", pos, p0 + 26'd1);
    $display("test direction done");
  endtask
  task automatic t_taught_cyclic;
    // falling taught travel: origin 5098, end 4098, length 1001
    cfg(1'b0, 2'h1, 2'h1, 1'b1, 1'b1, 27'h0);
    teach(1'b0);
    chk("cyc armed", armed, 1);
    move(26'd4098, 1'b0, 26'd64);
    teach(1'b1);
    chk("cyc taught", err, 0);
    wait_code("neg end", 16'hFFFF);
    move(26'd3598, 1'b0, 26'd64);
    wait_code("neg mid", scale(499, 1001));
    move(26'd4097, 1'b1, 26'd64);
    wait_code("neg wrap", 16'h0000);
    // an oversize count is clamped to full resolution
    cfg(1'b0, 2'h1, 2'h2, 1'b1, 1'b1, 27'h7FFFFFF);
    wait_code("clamped", scale(4097, 67108864));
    $display("test taught cyclic done");
  endtask
  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (16) @(negedge i_clk);
    i_reset = 1'b0;
    @(negedge i_clk);
    t_reset();
    t_ranges();
    t_teach();
    t_errors();
    t_counted();
    t_dir();
    t_taught_cyclic();
    end_of_test();
  end
  // the run needs some 8000 cycles, so 30000 means a hang
  initial begin
    repeat (30000) @(posedge i_clk);
    failures++;
    end_of_test();
  end
endmodule
